/* design/low_power_pkg.sv */
// constants and types for the low-power mode controller
// Function
// RULE_01: halt with stop_select clear enters light sleep.
// RULE_02: halt with stop_select set enters system-stop instead.
// RULE_03: clock generator and system/E clock outputs keep running; CPU stops.
// RULE_04: in sleep, DMA, timer, serial channels, pin controller keep running.
// RULE_05: in system-stop, DMA, timer, serial channels, pin controller stop.
// RULE_06: chip-select, wait-state and refresh controllers run in both modes.
// RULE_07: bus status outputs driven low in either low-power mode.
// RULE_08: RAM and CPU register contents kept while in low-power mode.
// RULE_09: sleep accepts internal and external interrupts.
// RULE_10: system-stop accepts external interrupts only; internal ones not generated.
// RULE_11: power-on or manual reset exits either mode, then reset processing.
// RULE_12: accepted interrupt ends sleep; masked request does not.
// RULE_13: non-maskable interrupt always ends either mode.
// RULE_14: after sleep ends by interrupt, stop_select stays clear.
// RULE_15: unmasked external interrupt ends system-stop; masked one does not.
// RULE_16: after system-stop ends by interrupt, stop_select stays set.
// RULE_17: software stops the DMA controller before halting into system-stop.
// RULE_18: reset clears stop_select so halt defaults to sleep.
// RULE_19: external bus requests are honoured and granted in both modes.
package low_power_pkg;

	localparam logic [7:0] BANK_MODE_CONTROL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] BANK_MODE_CONTROL_RESET = 8'hA4;
	localparam int STOP_SELECT_BIT = 3;
	localparam logic [2:0] BUS_STATUS_NEGATED = 3'h0;

	typedef enum logic [2:0] {
		RUN_STATE = 3'b001,
		SLEEP_STATE = 3'b010,
		STOP_STATE = 3'b100
	} power_state_t;

	// clock enables fanned out to the chip
	typedef struct packed {
		logic cpuClockEnable;
		logic peripheralClockEnable;
		logic memoryCtrlClockEnable;
		logic clockOutEnable;
	} clock_gates_t;

	// pending interrupt requests, already masked by priority/state registers
	typedef struct packed {
		logic nmi;
		logic extLine0;
		logic extLine1;
		logic internal;
	} wake_requests_t;

endpackage

/* design/low_power_mode_control.sv */
// low-power mode controller: sleep and system-stop sequencing
`timescale 1ns/1ps

module low_power_mode_control
	import low_power_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] regAddress,
	input wire logic [7:0] regWriteData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regReadData,
	input wire logic haltExecuted,
	input wire wake_requests_t wakeRequests,
	input wire logic [2:0] cpuBusStatus,
	input wire logic bus_request_in,
	output logic busGrant,
	output clock_gates_t clockGates,
	output logic internalIrqEnable,
	output logic [2:0] bus_status_outputs,
	output logic wakeAccepted,
	output logic stop_select,
	output power_state_t powerState
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	power_state_t state_reg;
	power_state_t state_next;
	logic [7:0] bankMode_reg;
	logic [7:0] bankMode_next;
	logic [7:0] readData_reg;
	logic [7:0] readData_next;
	logic wake_reg;
	logic [2:0] busStatus_reg;
	logic grant_reg;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire logic hitBankMode = regAddress == BANK_MODE_CONTROL_OFFSET;
	wire logic hitStatus = regAddress == STATUS_OFFSET;
	wire logic inRun = state_reg == RUN_STATE;
	wire logic inSleep = state_reg == SLEEP_STATE;
	wire logic inStop = state_reg == STOP_STATE;
	wire logic extWake = wakeRequests.extLine0 | wakeRequests.extLine1;
	// masking is done upstream; only unmasked requests arrive here
	wire logic sleepWake = wakeRequests.nmi | extWake | wakeRequests.internal; // RULE_09 RULE_12 RULE_13
	wire logic stopWake = wakeRequests.nmi | extWake; // RULE_10 RULE_13 RULE_15
	wire logic exitNow = (inSleep & sleepWake) | (inStop & stopWake);

	// bank mode writes only land while the CPU runs, so a wake leaves the bit as it was
	always_comb begin
		bankMode_next = bankMode_reg;
		if (regWrite && hitBankMode && inRun) begin
			bankMode_next = regWriteData;
		end
	end

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			RUN_STATE: begin
				if (haltExecuted) begin
					// stop_select picks the depth of the low-power state
					state_next = bankMode_reg[STOP_SELECT_BIT] ? STOP_STATE : SLEEP_STATE; // RULE_01 RULE_02
				end
			end
			SLEEP_STATE: begin
				if (sleepWake) begin
					state_next = RUN_STATE; // RULE_12 RULE_14
				end
			end
			STOP_STATE: begin
				if (stopWake) begin
					state_next = RUN_STATE; // RULE_15 RULE_16
				end
			end
			default: begin
				state_next = RUN_STATE;
			end
		endcase
	end

	always_comb begin
		readData_next = 8'h00;
		if (regRead && hitBankMode) begin
			readData_next = bankMode_reg;
		end else if (regRead && hitStatus) begin
			readData_next = {5'h00, state_reg};
		end
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= RUN_STATE; // RULE_11
			bankMode_reg <= BANK_MODE_CONTROL_RESET; // RULE_18
		end else begin
			state_reg <= state_next;
			bankMode_reg <= bankMode_next;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			readData_reg <= 8'h00;
			wake_reg <= 1'b0;
			busStatus_reg <= BUS_STATUS_NEGATED;
			grant_reg <= 1'b0;
		end else begin
			readData_reg <= readData_next;
			wake_reg <= exitNow;
			busStatus_reg <= (inRun && !haltExecuted) ? cpuBusStatus : BUS_STATUS_NEGATED; // RULE_07
			grant_reg <= bus_request_in; // RULE_19
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// gating enables only; no state is cleared, so RAM and CPU registers hold
	assign clockGates.cpuClockEnable = inRun; // RULE_03 RULE_08
	assign clockGates.peripheralClockEnable = !inStop; // RULE_04 RULE_05
	assign clockGates.memoryCtrlClockEnable = 1'b1; // RULE_06
	assign clockGates.clockOutEnable = 1'b1; // RULE_03
	assign internalIrqEnable = !inStop; // RULE_10
	assign bus_status_outputs = busStatus_reg;
	assign busGrant = grant_reg;
	assign wakeAccepted = wake_reg;
	assign stop_select = bankMode_reg[STOP_SELECT_BIT];
	assign powerState = state_reg;
	assign regReadData = readData_reg;

endmodule // low_power_mode_control

/* dv/lpm_properties.sv */
// port-level properties of the low-power controller
`timescale 1ns/1ps
module lpm_properties
	import low_power_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic haltExecuted,
	input wire wake_requests_t wakeRequests,
	input wire logic bus_request_in,
	input wire logic busGrant,
	input wire logic wakeAccepted,
	input wire clock_gates_t clockGates,
	input wire logic internalIrqEnable,
	input wire logic [2:0] bus_status_outputs,
	input wire logic stop_select,
	input wire power_state_t powerState
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire low = powerState != RUN_STATE;
	entry_mode_a: assert property (haltExecuted && !low
		|=> powerState == ($past(stop_select) ? STOP_STATE : SLEEP_STATE)) else $error("wrong mode");
	clocks_kept_a: assert property (low |-> clockGates[1:0] == 2'h3 && !clockGates[3])
		else $error("clock gates wrong");
	periph_gate_a: assert property (low |-> clockGates[2] == (powerState == SLEEP_STATE)
		&& internalIrqEnable == clockGates[2]) else $error("peripheral gate wrong");
	status_low_a: assert property (low |-> bus_status_outputs == BUS_STATUS_NEGATED)
		else $error("status not low");
	wake_exit_a: assert property ((powerState == SLEEP_STATE && |wakeRequests)
		|| (powerState == STOP_STATE && |wakeRequests[3:1]) |-> ##[1:2] !low) else $error("no wake");
	stop_stays_a: assert property (powerState == STOP_STATE && !(|wakeRequests[3:1])
		|=> powerState == STOP_STATE) else $error("left stop");
	select_hold_a: assert property (low |=> $stable(stop_select)) else $error("select moved");
	grant_low_a: assert property (low && bus_request_in |=> busGrant) else $error("no grant");
	grant_follow_a: assert property (!$past(rst) |-> busGrant == $past(bus_request_in))
		else $error("grant not following request");
	wake_pulse_a: assert property ($past(low) && !low && !$past(rst) |-> wakeAccepted)
		else $error("wake not flagged");
	wake_only_a: assert property (wakeAccepted |-> $past(low) && !low)
		else $error("spurious wake flag");
endmodule // lpm_properties

/* dv/cpu_side_model.sv */
// cpu and interrupt controller side: halt pulse and masked wake levels
`timescale 1ns/1ps
module cpu_side_model
	import low_power_pkg::*;
(
	input wire logic clock,
	input wire logic haltReq,
	input wire wake_requests_t wakeReq,
	output logic haltExecuted,
	output wake_requests_t wakeRequests
);
	always_ff @(posedge clock) begin
		haltExecuted <= haltReq;
		wakeRequests <= wakeReq;
	end
endmodule // cpu_side_model

/* dv/low_power_mode_control_tb.sv */
// self-checking bench for the low-power controller
`timescale 1ns/1ps
module low_power_mode_control_tb;
	import low_power_pkg::*;
	logic clock = 0, rst = 1, regWrite = 0, regRead = 0, haltReq = 0, bus_request_in = 0;
	logic [7:0] regAddress = 0, regWriteData = 0, regReadData;
	logic [2:0] cpuBusStatus = 3'h5, bus_status_outputs;
	wake_requests_t wakeRequests, wakeReq = '0;
	clock_gates_t clockGates;
	power_state_t powerState;
	logic haltExecuted, busGrant, internalIrqEnable, wakeAccepted, stop_select;
	int num_errors = 0, cmp_count = 0;
	low_power_mode_control low_power_mode_control_i(.*);
	cpu_side_model cpu_side_model_i(.clock, .haltReq, .wakeReq, .haltExecuted, .wakeRequests);
	initial forever #4 clock = ~clock;
	task automatic check(logic [7:0] seen, logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
		regWrite <= w;
		regRead <= !w;
		regAddress <= a;
		regWriteData <= d;
		@(posedge clock);
		regWrite <= 0;
		regRead <= 0;
		#1;
	endtask
	task automatic halt_wait();
		haltReq <= 1;
		@(posedge clock);
		haltReq <= 0;
		repeat (3) @(posedge clock);
	endtask
	// enter a mode, offer one wake pattern; nmi clears whatever stays asleep
	task automatic lp(logic s, logic [3:0] w, power_state_t st, logic wk);
		bus(1, 8'h00, 8'hA4 | {4'h0, s, 3'h0});
		halt_wait();
		check(powerState, st);
		check(bus_status_outputs, 0);
		bus(1, 8'h00, 8'hA4);
		wakeReq <= w;
		repeat (4) @(posedge clock);
		wakeReq <= '0;
		#1;
		check(powerState, wk ? RUN_STATE : st);
		check(stop_select, s);
		wakeReq.nmi <= 1;
		@(posedge clock);
		wakeReq <= '0;
		repeat (3) @(posedge clock);
		check(bus_status_outputs, 3'h5);
	endtask
	task automatic test_done();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clock);
		rst <= 0;
		bus_request_in <= 1;
		@(posedge clock);
		bus(0, 8'h00, 0);
		check(regReadData, 8'hA4);
		bus(0, 8'h44, 0);
		check(regReadData, 0);
		lp(0, 4'h1, SLEEP_STATE, 1);
		lp(0, 4'h0, SLEEP_STATE, 0);
		lp(1, 4'h1, STOP_STATE, 0);
		lp(1, 4'h4, STOP_STATE, 1);
		lp(1, 4'h2, STOP_STATE, 1);
		lp(0, 4'h8, SLEEP_STATE, 1);
		check(busGrant, 1);
		bus_request_in <= 0;
		bus(1, 8'h00, 8'hAC);
		halt_wait();
		check(busGrant, 0);
		rst <= 1;
		@(posedge clock);
		rst <= 0;
		#1;
		check(powerState, RUN_STATE);
		check(stop_select, 0);
		test_done();
	end
endmodule // low_power_mode_control_tb
bind low_power_mode_control lpm_properties lpm_properties_i(.*);
